//--- core/sdrc_consts.svh
`ifndef SDRC_CONSTS_SVH
`define SDRC_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SDRC_ADDR_CTRL0      8'h00
`define SDRC_ADDR_CTRL1      8'h01
`define SDRC_ADDR_RES_LOW    8'h02
`define SDRC_ADDR_RES_MID    8'h03
`define SDRC_ADDR_RES_HIGH   8'h04
`define SDRC_ADDR_CHAN       8'h05

// ----------------------------------------
// Control 0 fields
// ----------------------------------------
`define SDRC_C0_POWER_DOWN   7
`define SDRC_C0_FILTER_RST   6
`define SDRC_C0_REF_SEL      3
`define SDRC_C0_RATE_LSB     0
`define SDRC_C0_RESET        8'h80

// ----------------------------------------
// Control 1 fields
// ----------------------------------------
`define SDRC_C1_LATCH_EN     5
`define SDRC_C1_DONE         1
`define SDRC_C1_MODE_LSB     2
`define SDRC_C1_RESET        8'h00

// ----------------------------------------
// Channel select: temperature sensor pair
// ----------------------------------------
`define SDRC_CHAN_TEMP_POS   4'hc
`define SDRC_CHAN_TEMP_NEG   4'hc
`define SDRC_CHAN_RESET      8'h00

// ----------------------------------------
// Result limits and scaling
// ----------------------------------------
`define SDRC_FULL_POS        24'h7fffff
`define SDRC_FULL_NEG        24'h800000
`define SDRC_SCALE_K         32'h00800000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SDRC_CLK_HZ          250000000
`define SDRC_RATE_10HZ       10
`define SDRC_PERIOD_10HZ     (`SDRC_CLK_HZ / `SDRC_RATE_10HZ)
`define SDRC_RATE_10HZ_CODE  3'h1
`define SDRC_MODE_10HZ_CODE  3'h0

`endif

//--- core/sdrc_pkg.sv
package sdrc_pkg;
    typedef enum logic [1:0] {SDRC_OFF, SDRC_HOLD, SDRC_RUN} sdrc_state_t;
    typedef logic [23:0] sdrc_code_t;
endpackage

//--- core/sdrc_rate.sv
`include "sdrc_consts.svh"

// ----------------------------------------
// Output data rate timer
// ----------------------------------------
module sdrc_rate
    import sdrc_pkg::*;
#(
    parameter int unsigned PERIOD_10HZ = `SDRC_PERIOD_10HZ // Cycles per result at 10 Hz
)
(
    input wire logic clk,            // System clock
    input wire logic rst,            // Synchronous reset
    input wire logic run,            // Converter running
    input wire logic [2:0] rate_sel, // Output rate field
    input wire logic [2:0] mode_sel, // Filter mode field
    output logic tick                // Conversion end pulse
);
    logic [31:0] cnt_ff;
    logic [31:0] period;

    // Other settings keep the 10 Hz period; only that pair is defined
    always_comb begin
        period = PERIOD_10HZ;
        if (rate_sel == `SDRC_RATE_10HZ_CODE && mode_sel == `SDRC_MODE_10HZ_CODE) begin
            period = PERIOD_10HZ;
        end
    end

    // Restart from zero whenever held, so the first result takes a full period
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_ff <= 32'h0;
        end else if (cnt_ff >= period - 32'h1) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    assign tick = run && (cnt_ff >= period - 32'h1);
endmodule

//--- core/sdrc_scale.sv
`include "sdrc_consts.svh"

// ----------------------------------------
// Ratio to code with full-scale clamp
// ----------------------------------------
module sdrc_scale
    import sdrc_pkg::*;
(
    input wire logic clk,                 // System clock
    input wire logic rst,                 // Synchronous reset
    input wire logic signed [31:0] sig_in, // Amplified input
    input wire logic [31:0] ref_in,       // Amplified reference
    output sdrc_code_t code_ff            // Clamped result
);
    logic signed [63:0] prod;
    logic signed [63:0] quot;
    logic signed [63:0] lim_pos;
    logic signed [63:0] lim_neg;

    // Code = input / reference times K
    always_comb begin
        prod = 64'(sig_in) * $signed({32'h0, `SDRC_SCALE_K});
        lim_pos = 64'sh00000000007fffff;
        lim_neg = -64'sh0000000000800000;
        if (ref_in == 32'h0) begin
            quot = (sig_in < 0) ? lim_neg : lim_pos;
        end else begin
            quot = prod / $signed({32'h0, ref_in});
        end
    end

    // Saturate rather than wrap; wrap would flip the sign
    always_ff @(posedge clk) begin
        if (rst) begin
            code_ff <= 24'h000000;
        end else if (quot > lim_pos) begin
            code_ff <= `SDRC_FULL_POS;
        end else if (quot < lim_neg) begin
            code_ff <= `SDRC_FULL_NEG;
        end else begin
            code_ff <= quot[23:0];
        end
    end
endmodule

//--- core/sdrc_top.sv
// What this block does
// - Power-down bit switches all converter circuitry off
// - Results are 24-bit two's complement codes
// - Top result bit is the sign
// - Out-of-range inputs clamp to full scale
// - Code is input over reference times K
// - Reset bit holds filter; clearing starts conversion
// - Rate 001 with mode 000 gives 10 Hz
// - Result readable as low, middle, high bytes
// - Reference select picks regulator and ground pair
// - Temperature sensor pair feeds converter input
// - End of conversion sets flag and request
// - New results overwrite; latch enable holds the first one taken after it
`include "sdrc_consts.svh"

module sdrc_top
    import sdrc_pkg::*;
#(
    parameter int unsigned CONV_PERIOD = `SDRC_PERIOD_10HZ // Cycles per 10 Hz result; smaller only to shorten waits
)
(
    input wire logic clk,                   // System clock, 250 MHz
    input wire logic rst,                   // Synchronous reset, active high
    input wire logic [7:0] addr,            // Register address
    input wire logic [7:0] wdata,           // Write data
    input wire logic wr,                    // Write strobe
    input wire logic rd,                    // Read strobe
    output logic [7:0] rdata_ff,            // Read data, cycle after rd
    input wire logic signed [31:0] chan_sig, // Amplified selected input
    input wire logic signed [31:0] temp_sig, // Amplified sensor output
    input wire logic [31:0] ref_cm,         // Amplified common-mode reference
    input wire logic [31:0] ref_reg,        // Amplified regulator reference
    output logic analog_enable,             // Converter circuitry powered
    output logic filter_reset,              // Filter held in reset
    output logic ref_use_regulator,         // Reference from regulator pair
    output logic temp_sensor_enable,        // Sensor pair selected
    output logic conv_irq                   // Conversion request pulse
);
    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic conv_power_down_ff;
    logic conv_filter_reset_ff;
    logic reference_pair_select_ff;
    logic [2:0] output_rate_select_ff;
    logic [2:0] filter_mode_select_ff;
    logic latch_enable_ff;
    logic conv_done_ff;
    logic [3:0] chan_pos_ff;
    logic [3:0] chan_neg_ff;
    logic [7:0] result_low_byte_ff;
    logic [7:0] result_middle_byte_ff;
    logic [7:0] result_high_byte_ff;
    logic latched_ff;
    logic load_pending_ff;
    sdrc_state_t state_ff;
    sdrc_state_t nxt_state;
    logic [7:0] nxt_rdata;
    logic run;
    logic tick;
    logic use_temp;
    logic signed [31:0] sel_sig;
    logic [31:0] sel_ref;
    sdrc_code_t code;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Software-written control bits
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_power_down_ff <= 1'b1;
            conv_filter_reset_ff <= 1'b0;
            reference_pair_select_ff <= 1'b0;
            output_rate_select_ff <= 3'h0;
            filter_mode_select_ff <= 3'h0;
            latch_enable_ff <= 1'b0;
            chan_pos_ff <= 4'h0;
            chan_neg_ff <= 4'h0;
        end else if (wr) begin
            if (hit(addr, `SDRC_ADDR_CTRL0)) begin
                conv_power_down_ff <= wdata[`SDRC_C0_POWER_DOWN];
                conv_filter_reset_ff <= wdata[`SDRC_C0_FILTER_RST];
                reference_pair_select_ff <= wdata[`SDRC_C0_REF_SEL];
                output_rate_select_ff <= wdata[`SDRC_C0_RATE_LSB +: 3];
            end
            if (hit(addr, `SDRC_ADDR_CTRL1)) begin
                latch_enable_ff <= wdata[`SDRC_C1_LATCH_EN];
                filter_mode_select_ff <= wdata[`SDRC_C1_MODE_LSB +: 3];
            end
            if (hit(addr, `SDRC_ADDR_CHAN)) begin
                chan_pos_ff <= wdata[7:4];
                chan_neg_ff <= wdata[3:0];
            end
        end
    end

    // ----------------------------------------
    // Operating state
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SDRC_OFF: if (!conv_power_down_ff) nxt_state = conv_filter_reset_ff ? SDRC_HOLD : SDRC_OFF;
            SDRC_HOLD: if (conv_power_down_ff) nxt_state = SDRC_OFF;
                else if (!conv_filter_reset_ff) nxt_state = SDRC_RUN;
            SDRC_RUN: if (conv_power_down_ff) nxt_state = SDRC_OFF;
                else if (conv_filter_reset_ff) nxt_state = SDRC_HOLD;
        endcase
    end

    // Conversion only starts after a reset pulse out of power-down
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= SDRC_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign run = (state_ff == SDRC_RUN) && !conv_power_down_ff && !conv_filter_reset_ff;
    assign analog_enable = !conv_power_down_ff;
    assign filter_reset = conv_filter_reset_ff || (state_ff != SDRC_RUN);
    assign ref_use_regulator = reference_pair_select_ff;
    assign use_temp = (chan_pos_ff == `SDRC_CHAN_TEMP_POS) && (chan_neg_ff == `SDRC_CHAN_TEMP_NEG);
    assign temp_sensor_enable = use_temp && analog_enable;

    // ----------------------------------------
    // Input and reference selection
    // ----------------------------------------
    always_comb begin
        sel_sig = use_temp ? temp_sig : chan_sig;
        sel_ref = reference_pair_select_ff ? ref_reg : ref_cm;
        if (conv_power_down_ff) begin
            sel_sig = 32'sh0;
        end
    end

    sdrc_scale u_scale (
        .clk(clk),
        .rst(rst),
        .sig_in(sel_sig),
        .ref_in(sel_ref),
        .code_ff(code)
    );

    sdrc_rate #(.PERIOD_10HZ(CONV_PERIOD)) u_rate (
        .clk(clk),
        .rst(rst),
        .run(run),
        .rate_sel(output_rate_select_ff),
        .mode_sel(filter_mode_select_ff),
        .tick(tick)
    );

    // ----------------------------------------
    // Result capture
    // ----------------------------------------
    // Load one cycle after the tick so the scaled code is fresh
    always_ff @(posedge clk) begin
        if (rst) begin
            load_pending_ff <= 1'b0;
        end else begin
            load_pending_ff <= tick;
        end
    end

    // Latch holds the first result taken while enabled
    always_ff @(posedge clk) begin
        if (rst || !latch_enable_ff) begin
            latched_ff <= 1'b0;
        end else if (load_pending_ff) begin
            latched_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            result_low_byte_ff <= 8'h00;
            result_middle_byte_ff <= 8'h00;
            result_high_byte_ff <= 8'h00;
        end else if (load_pending_ff && !latched_ff) begin
            result_low_byte_ff <= code[7:0];
            result_middle_byte_ff <= code[15:8];
            result_high_byte_ff <= code[23:16];
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_done_ff <= 1'b0;
        end else if (load_pending_ff) begin
            conv_done_ff <= 1'b1;
        end else if (wr && hit(addr, `SDRC_ADDR_CTRL1) && !wdata[`SDRC_C1_DONE]) begin
            conv_done_ff <= 1'b0;
        end
    end

    assign conv_irq = load_pending_ff;

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit(addr, `SDRC_ADDR_CTRL0)) begin
            nxt_rdata = {conv_power_down_ff, conv_filter_reset_ff, 2'b00, reference_pair_select_ff,
                         output_rate_select_ff};
        end else if (hit(addr, `SDRC_ADDR_CTRL1)) begin
            nxt_rdata = {2'b00, latch_enable_ff, filter_mode_select_ff, conv_done_ff, 1'b0};
        end else if (hit(addr, `SDRC_ADDR_RES_LOW)) begin
            nxt_rdata = result_low_byte_ff;
        end else if (hit(addr, `SDRC_ADDR_RES_MID)) begin
            nxt_rdata = result_middle_byte_ff;
        end else if (hit(addr, `SDRC_ADDR_RES_HIGH)) begin
            nxt_rdata = result_high_byte_ff;
        end else if (hit(addr, `SDRC_ADDR_CHAN)) begin
            nxt_rdata = {chan_pos_ff, chan_neg_ff};
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst || !rd) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
endmodule

//--- sim/sdrc_props.sv
`include "sdrc_consts.svh"

module sdrc_props
    import sdrc_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Sync reset
    input wire logic [7:0] addr, // Address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [7:0] rdata_ff, // Read data
    input wire logic signed [31:0] chan_sig, // Channel input
    input wire logic signed [31:0] temp_sig, // Sensor input
    input wire logic [31:0] ref_cm, // Common-mode ref
    input wire logic [31:0] ref_reg, // Regulator ref
    input wire logic analog_enable, // Powered
    input wire logic filter_reset, // Filter held
    input wire logic ref_use_regulator, // Ref select
    input wire logic temp_sensor_enable, // Sensor pair on
    input wire logic conv_irq // Result pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Off state seen as one level so a pipelined pulse may drain
    wire held_off = !analog_enable || filter_reset;
    a_pwr_follow: assert property (wr && addr == `SDRC_ADDR_CTRL0 |=> analog_enable == !$past(wdata[7]))
        else $error("power control not followed");
    a_pwr_sensor: assert property (!analog_enable |-> !temp_sensor_enable)
        else $error("sensor on while powered down");
    a_filt_hold: assert property (wr && addr == `SDRC_ADDR_CTRL0 && wdata[6] |=> filter_reset)
        else $error("filter not held");
    a_rst_state: assert property ($fell(rst) |-> filter_reset && !analog_enable)
        else $error("wrong state after reset");
    a_ref_follow: assert property (wr && addr == `SDRC_ADDR_CTRL0 |=> ref_use_regulator == $past(wdata[3]))
        else $error("reference select not followed");
    a_temp_sel: assert property (wr && addr == `SDRC_ADDR_CHAN
        |=> temp_sensor_enable == ($past(wdata) == 8'hcc && analog_enable))
        else $error("sensor select wrong");
    a_no_irq_off: assert property (held_off && $past(held_off) && $past(held_off, 2) |-> !conv_irq)
        else $error("result while held off");
    a_irq_pulse: assert property (conv_irq |=> !conv_irq)
        else $error("request longer than one cycle");
    a_rd_idle: assert property (!rd |=> rdata_ff == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_rd: assert property (rd && addr > `SDRC_ADDR_CHAN |=> rdata_ff == 8'h00)
        else $error("unmapped read not zero");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    c_power_up: cover property (wr && addr == `SDRC_ADDR_CTRL0 && wdata == 8'h40);
    c_sensor: cover property (temp_sensor_enable);
    c_res_read: cover property (rd && addr == `SDRC_ADDR_RES_LOW);
    c_result: cover property (conv_irq);
endmodule

bind sdrc_top sdrc_props i_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .chan_sig(chan_sig), .temp_sig(temp_sig), .ref_cm(ref_cm), .ref_reg(ref_reg),
    .analog_enable(analog_enable), .filter_reset(filter_reset), .ref_use_regulator(ref_use_regulator),
    .temp_sensor_enable(temp_sensor_enable), .conv_irq(conv_irq));

//--- sim/tb.sv
`include "sdrc_consts.svh"

module tb import sdrc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_ff, a;
    logic signed [31:0] chan_sig = 32'sh0, temp_sig = 32'sh0;
    logic [31:0] ref_cm = 32'h00400000, ref_reg = 32'h00400000, seed = 32'h1f8a;
    logic analog_enable, filter_reset, ref_use_regulator, temp_sensor_enable, conv_irq;
    logic [7:0] exp_q[$];
    logic [23:0] ex;
    int mismatches = 0, cmp_count = 0;

    always #2 clk = ~clk;

    // Short result period so several conversions fit in the run
    sdrc_top #(.CONV_PERIOD(500)) i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_ff(rdata_ff),
        .chan_sig(chan_sig), .temp_sig(temp_sig), .ref_cm(ref_cm), .ref_reg(ref_reg),
        .analog_enable(analog_enable), .filter_reset(filter_reset), .ref_use_regulator(ref_use_regulator),
        .temp_sensor_enable(temp_sensor_enable), .conv_irq(conv_irq));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Expected code: input over reference times 2^23, clamped to full scale
    function automatic logic [23:0] conv_exp(input longint sig, input longint rf);
        longint q;
        q = (sig * 64'sh800000) / rf;
        if (q > 64'sh7fffff) q = 64'sh7fffff;
        if (q < -64'sh800000) q = -64'sh800000;
        return q[23:0];
    endfunction

    // Bounded wait for a conversion pulse; running out ends the run
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (conv_irq !== 1'b1 && n < 2000);
        if (conv_irq !== 1'b1) begin
            mismatches++;
            $display("unexpected conv_irq expected 1 seen %b", conv_irq);
            wrap_up();
        end
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle strobes, launched after an edge and dropped after the next
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= ad;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= ad;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // Read data monitor
    // ----------------------------------------
    // Read data stand one cycle only, so sample at the falling edge
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d && exp_q.size() > 0) chk("rdata_ff", exp_q.pop_front(), rdata_ff);
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("analog_enable", 8'h00, 8'(analog_enable));
        chk("filter_reset", 8'h01, 8'(filter_reset));
        rreg(`SDRC_ADDR_CTRL0, `SDRC_C0_RESET);
        rreg(`SDRC_ADDR_CTRL1, 8'h00);
        for (int i = 2; i < 6; i++) rreg(8'(i), 8'h00);
        $display("test reset done");
        seed = xs(seed);
        wreg(`SDRC_ADDR_CTRL0, 8'h40);
        @(negedge clk);
        chk("analog_enable", 8'h01, 8'(analog_enable));
        chk("filter_reset", 8'h01, 8'(filter_reset));
        wreg(`SDRC_ADDR_CTRL0, 8'h08 | seed[2:0]);
        // Hold state needs one more edge to reach run
        repeat (2) @(negedge clk);
        chk("filter_reset", 8'h00, 8'(filter_reset));
        chk("ref_use_regulator", 8'h01, 8'(ref_use_regulator));
        rreg(`SDRC_ADDR_CTRL0, 8'h08 | seed[2:0]);
        wreg(`SDRC_ADDR_CTRL0, {5'h00, seed[2:0]});
        @(negedge clk);
        chk("ref_use_regulator", 8'h00, 8'(ref_use_regulator));
        // Writing one to the done flag must leave it clear
        wreg(`SDRC_ADDR_CTRL1, {2'b00, 1'b1, seed[5:3], 2'b10});
        rreg(`SDRC_ADDR_CTRL1, {2'b00, 1'b1, seed[5:3], 2'b00});
        $display("test control done");
        for (int i = 2; i < 5; i++) begin
            wreg(8'(i), 8'hff);
            rreg(8'(i), 8'h00);
        end
        repeat (4) begin
            seed = xs(seed);
            a = 8'h06 + (seed[7:0] % 8'd250);
            wreg(a, seed[15:8]);
            rreg(a, 8'h00);
        end
        $display("test read-only done");
        wreg(`SDRC_ADDR_CHAN, 8'hcc);
        @(negedge clk);
        chk("temp_sensor_enable", 8'h01, 8'(temp_sensor_enable));
        rreg(`SDRC_ADDR_CHAN, 8'hcc);
        wreg(`SDRC_ADDR_CHAN, 8'hc3);
        @(negedge clk);
        chk("temp_sensor_enable", 8'h00, 8'(temp_sensor_enable));
        wreg(`SDRC_ADDR_CHAN, 8'hcc);
        wreg(`SDRC_ADDR_CTRL0, 8'h80);
        @(negedge clk);
        chk("temp_sensor_enable", 8'h00, 8'(temp_sensor_enable));
        $display("test sensor done");
        // Three fifths of one result period, so no result may appear yet
        wreg(`SDRC_ADDR_CTRL0, 8'h40);
        wreg(`SDRC_ADDR_CTRL0, 8'h01);
        repeat (300) begin
            @(posedge clk);
            seed = xs(seed);
            chan_sig <= seed;
            temp_sig <= ~seed;
            @(negedge clk);
            chk("conv_irq", 8'h00, 8'(conv_irq));
        end
        // Latch off, rate 001 with mode 000, known sensor level
        wreg(`SDRC_ADDR_CTRL1, 8'h00);
        @(posedge clk);
        temp_sig <= 32'sh00123456;
        ex = conv_exp(32'sh00123456, ref_cm);
        wait_irq();
        rreg(`SDRC_ADDR_RES_LOW, ex[7:0]);
        rreg(`SDRC_ADDR_RES_MID, ex[15:8]);
        rreg(`SDRC_ADDR_RES_HIGH, ex[23:16]);
        rreg(`SDRC_ADDR_CTRL1, 8'h02);
        wreg(`SDRC_ADDR_CTRL1, 8'h20);
        rreg(`SDRC_ADDR_CTRL1, 8'h20);
        // Below negative full scale, taken while the latch is on
        @(posedge clk);
        temp_sig <= 32'sh80000000;
        wait_irq();
        rreg(`SDRC_ADDR_RES_HIGH, 8'h80);
        rreg(`SDRC_ADDR_RES_LOW, 8'h00);
        @(posedge clk);
        temp_sig <= 32'sh7fffffff;
        wait_irq();
        rreg(`SDRC_ADDR_RES_HIGH, 8'h80);
        wreg(`SDRC_ADDR_CTRL1, 8'h00);
        wait_irq();
        rreg(`SDRC_ADDR_RES_HIGH, 8'h7f);
        rreg(`SDRC_ADDR_RES_LOW, 8'hff);
        $display("test result done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("filter_reset", 8'h01, 8'(filter_reset));
        $display("test run done");
        repeat (2) @(negedge clk);
        wrap_up();
    end
endmodule
